// >>> cantmc_map.vh
// constants and contract of the transceiver mode control
//
// Contract
// - bus transmit happens only in normal mode; bus receive in normal and receive-only mode
// - receive-only mode: transmitter off, bus state still reported on receive
// - standby: no transmission and no normal reception
// - standby: only wake comparator active, mirrors bus for wake-up only
// - transmit input low drives dominant, high leaves bus recessive
// - transmit input pulled up: undriven input reads high, bus recessive
// - transmit low longer than about 3 ms forces driver recessive
// - receive output high for recessive bus, low for dominant bus
// - standby request and receive-only select open pins read high
// - standby high wins; low/high normal; both low receive-only
// - normal mode refused while transmit input is held low
// - standby: dominant longer than wake filter time pulls receive low
// - wake-up never leaves standby; controller must drop standby request
`ifndef CANTMC_MAP_VH
`define CANTMC_MAP_VH

`define CANTMC_CLK_HZ        40000000
`define CANTMC_DOM_TO_US     3000
`define CANTMC_DOM_TO_CYC    ((`CANTMC_DOM_TO_US * (`CANTMC_CLK_HZ / 1000)) / 1000)
`define CANTMC_WAKE_NS       1000
`define CANTMC_WAKE_CYC      ((`CANTMC_WAKE_NS + 24) / 25)
`define CANTMC_CNT_W         18

`define CANTMC_MODE_STANDBY  2'h0
`define CANTMC_MODE_NORMAL   2'h1
`define CANTMC_MODE_LISTEN   2'h2
`define CANTMC_MODE_RST      2'h0

`endif

// >>> cantmc_buf2.v
// two-entry buffer on the receive data path
`timescale 1ns/1ps
module cantmc_buf2 (
    // clock and reset
    input  wire clk_sys,
    input  wire reset_n,
    // fill side
    input  wire in_valid,
    output wire in_ready,
    input  wire in_data,
    // drain side
    output wire out_valid,
    input  wire out_ready,
    output wire out_data
);
    reg  [1:0] data_ff;
    reg  [1:0] cnt_ff;
    wire       push;
    wire       pop;

    assign in_ready  = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data  = data_ff[0];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            data_ff <= 2'h3;
            cnt_ff  <= 2'h0;
        end else begin
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
            if (pop) begin
                data_ff[0] <= (cnt_ff == 2'h2) ? data_ff[1] : in_data;
                if (push && cnt_ff == 2'h2)
                    data_ff[1] <= in_data;
            end else if (push) begin
                if (cnt_ff == 2'h0)
                    data_ff[0] <= in_data;
                else
                    data_ff[1] <= in_data;
            end
        end
    end
endmodule

// >>> cantmc_ctrl.v
// mode decode, transmit gating, time-out and wake logic of the transceiver
`timescale 1ns/1ps
`include "cantmc_map.vh"
module cantmc_ctrl (
    // clock and reset
    input  wire clk_sys,
    input  wire reset_n,
    // controller side pins; *_driven low models an open pin (pull-up)
    input  wire txd_in,
    input  wire txd_driven,
    input  wire standby_request,
    input  wire standby_driven,
    input  wire receive_only_select_n,
    input  wire rx_sel_driven,
    output wire rxd_out,
    // stall from controller side receive consumer
    input  wire rxd_ready,
    output wire rxd_valid,
    // bus side: comparators high when bus dominant, driver output and bias enable
    input  wire bus_dominant_hs,
    input  wire wake_comparator,
    output wire bus_drive_dominant,
    output wire bus_bias_on,
    // status
    output wire [1:0] mode,
    output wire timeout_active,
    output wire wake_pending
);
    reg  [1:0]               mode_ff;
    reg  [1:0]               nxt_mode;
    reg  [`CANTMC_CNT_W-1:0] dom_cnt_ff;
    reg                      tout_ff;
    reg  [5:0]               wake_cnt_ff;
    reg                      wake_ff;
    reg                      prev_dom_ff;
    reg                      drive_ff;
    reg                      rx_bit;
    reg                      rx_valid_c;
    wire                     txd_eff;
    wire                     sreq_eff;
    wire                     rxsel_eff;
    wire                     buf_in_ready;

    // undriven pins read high through the pull-ups
    assign txd_eff   = txd_driven ? txd_in : 1'b1;
    assign sreq_eff  = standby_driven ? standby_request : 1'b1;
    assign rxsel_eff = rx_sel_driven ? receive_only_select_n : 1'b1;

    // mode selection; wake alone never changes mode
    always @* begin
        nxt_mode = mode_ff;
        if (sreq_eff)
            nxt_mode = `CANTMC_MODE_STANDBY;
        else if (!rxsel_eff)
            nxt_mode = `CANTMC_MODE_LISTEN;
        else if (txd_eff)
            nxt_mode = `CANTMC_MODE_NORMAL;
        else if (mode_ff != `CANTMC_MODE_NORMAL)
            nxt_mode = mode_ff;
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            mode_ff <= `CANTMC_MODE_RST;
        else
            mode_ff <= nxt_mode;
    end

    // dominant time-out; released only when transmit input goes high
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dom_cnt_ff <= {`CANTMC_CNT_W{1'b0}};
            tout_ff    <= 1'b0;
        end else if (txd_eff) begin
            dom_cnt_ff <= {`CANTMC_CNT_W{1'b0}};
            tout_ff    <= 1'b0;
        end else if (dom_cnt_ff >= `CANTMC_DOM_TO_CYC) begin
            tout_ff    <= 1'b1;
        end else begin
            dom_cnt_ff <= dom_cnt_ff + 1'b1;
        end
    end

    // driver registered so the bus sees a clean level
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            drive_ff <= 1'b0;
        else
            drive_ff <= (mode_ff == `CANTMC_MODE_NORMAL) &
                        !txd_eff & !tout_ff;
    end

    // wake filter: recessive then dominant longer than filter time
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wake_cnt_ff <= 6'h00;
            wake_ff     <= 1'b0;
            prev_dom_ff <= 1'b1;
        end else if (mode_ff != `CANTMC_MODE_STANDBY) begin
            wake_cnt_ff <= 6'h00;
            wake_ff     <= 1'b0;
            prev_dom_ff <= 1'b1;
        end else begin
            prev_dom_ff <= wake_comparator;
            if (!wake_comparator) begin
                wake_cnt_ff <= 6'h00;
                wake_ff     <= 1'b0;
            end else if (!prev_dom_ff || wake_cnt_ff != 6'h00) begin
                if (wake_cnt_ff >= `CANTMC_WAKE_CYC)
                    wake_ff <= 1'b1;
                else
                    wake_cnt_ff <= wake_cnt_ff + 6'h01;
            end
        end
    end

    // receive source per mode
    always @* begin
        rx_valid_c = 1'b1;
        case (mode_ff)
            `CANTMC_MODE_NORMAL: rx_bit = !bus_dominant_hs;
            `CANTMC_MODE_LISTEN: rx_bit = !bus_dominant_hs;
            `CANTMC_MODE_STANDBY: rx_bit = !wake_ff;
            default: begin
                rx_bit     = 1'b1;
                rx_valid_c = 1'b0;
            end
        endcase
    end

    // a stall downstream holds the first two samples; later ones are dropped while the buffer is full
    cantmc_buf2 u_rxbuf (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_valid  (rx_valid_c),
        .in_ready  (buf_in_ready),
        .in_data   (rx_bit),
        .out_valid (rxd_valid),
        .out_ready (rxd_ready),
        .out_data  (rxd_out)
    );

    assign bus_drive_dominant = drive_ff;
    assign bus_bias_on        = (mode_ff != `CANTMC_MODE_STANDBY);
    assign mode               = mode_ff;
    assign timeout_active     = tout_ff;
    assign wake_pending       = wake_ff;
endmodule

// >>> cantmc_checker_assertions.sv
// pin-level assertions of the transceiver mode control
`timescale 1ns/1ps
module cantmc_checker (
    // watched pins
    input wire       clk_sys,
    input wire       reset_n,
    input wire       txd_in,
    input wire       txd_driven,
    input wire       standby_request,
    input wire       standby_driven,
    input wire       receive_only_select_n,
    input wire       rx_sel_driven,
    input wire       bus_drive_dominant,
    input wire       bus_bias_on,
    input wire [1:0] mode,
    input wire       timeout_active,
    input wire       wake_pending
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_gate; mode != 2'h1 |=> !bus_drive_dominant; endproperty
    a_gate: assert property (p_gate) else $error("driver on");
    property p_idle;
        (txd_in || !txd_driven) [*2] |=> !bus_drive_dominant;
    endproperty
    a_idle: assert property (p_idle) else $error("idle tx");
    property p_standby;
        standby_request || !standby_driven |=> mode == 2'h0;
    endproperty
    a_standby: assert property (p_standby) else $error("standby");
    property p_listen; standby_driven && !standby_request && rx_sel_driven
        && !receive_only_select_n |=> mode == 2'h2; endproperty
    a_listen: assert property (p_listen) else $error("listen");
    property p_refuse;
        mode != 2'h1 && txd_driven && !txd_in |=> mode != 2'h1;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refuse");
    property p_bias; bus_bias_on == (mode != 2'h0); endproperty
    a_bias: assert property (p_bias) else $error("bias");
    property p_wake; $rose(wake_pending) |-> $past(mode) == 2'h0; endproperty
    a_wake: assert property (p_wake) else $error("wake");
    property p_to; timeout_active |=> !bus_drive_dominant; endproperty
    a_to: assert property (p_to) else $error("timeout");
    c_listen: cover property (mode == 2'h2);
    c_to: cover property ($rose(timeout_active));
    c_wake: cover property ($rose(wake_pending));
endmodule
bind cantmc_ctrl cantmc_checker chk_i (.*);

// >>> cantmc_host_model.sv
// receive consumer of the host controller, able to stall
`timescale 1ns/1ps
module cantmc_host_model (
    // stall request and handshake
    input  wire stall,
    output wire rxd_ready
);
    assign rxd_ready = !stall;
endmodule

// >>> can_transceiver_mode_control_tb_top.sv
// scenario testbench of the transceiver mode control
`timescale 1ns/1ps
module can_transceiver_mode_control_tb_top;
    reg clk_sys = 0, reset_n = 0, txd_in = 1, txd_driven = 1, remote = 0;
    reg standby_request = 1, standby_driven = 1, stall = 0;
    reg receive_only_select_n = 1, rx_sel_driven = 1;
    wire rxd_out, rxd_ready, rxd_valid, bus_drive_dominant, bus_bias_on;
    wire timeout_active, wake_pending;
    wire [1:0] mode;
    // dominant wins on the wire
    wire bus_dominant_hs = bus_drive_dominant | remote;
    wire wake_comparator = bus_dominant_hs;
    integer num_errors = 0, n_checks = 0, cycles = 0;
    cantmc_ctrl uut (.*);
    cantmc_host_model host (.*);
    initial forever #12.5 clk_sys = ~clk_sys;
    task cyc(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    // pins: standby, its driven, sel_n, sel driven, txd, txd driven
    task pins(input [5:0] v);
        begin
            @(posedge clk_sys);
            {standby_request, standby_driven, receive_only_select_n,
                rx_sel_driven, txd_in, txd_driven} <= v;
            cyc(6);
        end
    endtask
    task chk(input [1:0] got, input [1:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", n_checks, num_errors);
            if (num_errors == 0 && n_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task t_modes;
        begin
            pins(6'b011111); chk(mode, 2'h1);
            pins(6'b010111); chk(mode, 2'h2);
            pins(6'b001111); chk(mode, 2'h0);
            pins(6'b011011); chk(mode, 2'h1);
            pins(6'b110001); chk(mode, 2'h0);
            pins(6'b011101); chk(mode, 2'h0);
            $display("modes done");
        end
    endtask
    task t_path;
        begin
            pins(6'b011111); chk(rxd_out, 1);
            pins(6'b011101); chk(bus_drive_dominant, 1);
            chk(rxd_out, 0);
            pins(6'b011100); chk(bus_drive_dominant, 0);
            pins(6'b010101); chk(bus_drive_dominant, 0);
            remote <= 1; cyc(6); chk(rxd_out, 0);
            stall <= 1; remote <= 0; cyc(6);
            chk(rxd_out, 0);
            chk(rxd_valid, 1);
            stall <= 0; cyc(6); chk(rxd_out, 1);
            $display("path done");
        end
    endtask
    task t_wake;
        begin
            pins(6'b110011); remote <= 1; cyc(30);
            chk(wake_pending, 0);
            cyc(20); chk(wake_pending, 1);
            chk(rxd_out, 0);
            chk(mode, 2'h0);
            chk(bus_bias_on, 0);
            remote <= 0; pins(6'b011111); chk(mode, 2'h1);
            $display("wake done");
        end
    endtask
    task t_timeout;
        begin
            pins(6'b011101); cyc(119985);
            chk(timeout_active, 0);
            chk(bus_drive_dominant, 1);
            cyc(15); chk(timeout_active, 1);
            chk(bus_drive_dominant, 0);
            pins(6'b011111); chk(timeout_active, 0);
            pins(6'b011101); chk(bus_drive_dominant, 1);
            $display("timeout done");
        end
    endtask
    // hang guard, a little above the longest scenario
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 130000) begin
            num_errors = num_errors + 1;
            conclude;
        end
    end
    initial begin
        cyc(2);
        reset_n <= 1;
        t_modes;
        t_path;
        t_wake;
        t_timeout;
        conclude;
    end
endmodule
